// ==== src/serial_nvram.sv ====
// serial nonvolatile RAM slave: status byte, pause input, wrapping burst access
// assumes a mode 0 host that drives chip select, clock and pause; the serial
// clock stops between frames, so link logic relies only on frame edges
`timescale 1ns/1ps

module serial_nvram
  import nvram_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W_DEFAULT,
  parameter logic FIXED_BIT6 = `ST_FIXED_DEFAULT
) (
  // system clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // serial link from the host
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  // serial data out, enable active low
  output logic so_o,
  output logic so_oe_n_o,
  // status seen from the system side
  output logic [7:0] status_byte_o,
  output logic paused_o
);

  localparam int DEPTH = 1 << ADDR_W;

  // system domain state
  typedef struct packed {
    logic link_rst;
    logic [7:0] seen;
    logic [7:0] status;
    logic paused;
  } sys_t;

  sys_t sys_ff;
  sys_t nxt_sys;
  frame_t frame_ff;
  frame_t nxt_frame;
  stat_t stat_ff;
  stat_t nxt_stat;
  link_in_t pin;
  logic so_ff;
  logic [7:0] mem [DEPTH];
  logic [7:0] status_byte;
  logic [7:0] byte_in;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] inc_addr;
  logic protected_addr;
  logic mem_we;
  logic frame_clr;
  logic [7:0] status_sync;
  logic paused_sync;
  logic hold_lvl_ff;

  assign pin = '{cs_n: cs_n_i, si: si_i, hold_n: hold_n_i, wp_n: wp_n_i};

  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_BUSY_BIT] = 1'b0;
    status_byte[`ST_LATCH_BIT] = stat_ff.write_enable_latch;
    status_byte[`ST_PROT0_BIT] = stat_ff.block_protect_0;
    status_byte[`ST_PROT1_BIT] = stat_ff.block_protect_1;
    status_byte[`ST_FIXED_BIT] = FIXED_BIT6;
    status_byte[`ST_PIN_EN_BIT] = stat_ff.protect_pin_enable;
  end

  // address helpers; the counter spans the whole array
  assign byte_in = {frame_ff.shift[6:0], pin.si};
  assign cur_addr = frame_ff.addr[ADDR_W-1:0];
  assign inc_addr = (cur_addr == ADDR_W'(DEPTH - 1)) ? '0 : cur_addr + 1'b1;

  // block protect: upper quarter, upper half or all of the array
  always_comb begin
    unique case ({stat_ff.block_protect_1, stat_ff.block_protect_0})
      2'b00: protected_addr = 1'b0;
      2'b01: protected_addr = &cur_addr[ADDR_W-1 -: 2];
      2'b10: protected_addr = cur_addr[ADDR_W-1];
      2'b11: protected_addr = 1'b1;
    endcase
  end

  // link decode, one step per rising serial clock edge
  always_comb begin
    nxt_frame = frame_ff;
    nxt_stat = stat_ff;
    mem_we = 1'b0;
    if (pin.hold_n) begin
      nxt_frame.shift = byte_in;
      nxt_frame.bit_cnt = frame_ff.bit_cnt + 3'h1;
      if (frame_ff.bit_cnt == `LAST_BIT) begin
        unique case (frame_ff.phase)
          PH_CMD: begin
            nxt_frame.cmd = byte_in;
            nxt_frame.phase = PH_IDLE;
            unique case (byte_in)
              `OP_LATCH_SET: nxt_stat.write_enable_latch = 1'b1;
              `OP_LATCH_CLEAR: nxt_stat.write_enable_latch = 1'b0;
              `OP_STATUS_READ: begin
                nxt_frame.phase = PH_DATA;
                nxt_frame.out = status_byte;
              end
              `OP_STATUS_WRITE: nxt_frame.phase = PH_DATA;
              `OP_MEM_READ, `OP_MEM_WRITE: nxt_frame.phase = PH_ADDR;
              `OP_IGN_WAKE, `OP_IGN_PAGE_ERASE, `OP_IGN_SECTOR_ERASE:
                nxt_frame.phase = PH_IDLE;
              default: nxt_frame.phase = PH_IDLE;
            endcase
          end
          PH_ADDR: begin
            nxt_frame.addr = {frame_ff.addr[7:0], byte_in};
            nxt_frame.addr_byte = 1'b1;
            if (frame_ff.addr_byte) begin
              nxt_frame.phase = PH_DATA;
              if (frame_ff.cmd == `OP_MEM_READ) begin
                nxt_frame.out = mem[nxt_frame.addr[ADDR_W-1:0]];
                nxt_frame.addr = 16'(nxt_frame.addr[ADDR_W-1:0] == ADDR_W'(DEPTH - 1)
                  ? '0 : nxt_frame.addr[ADDR_W-1:0] + 1'b1);
              end
            end
          end
          PH_DATA: begin
            unique case (frame_ff.cmd)
              `OP_MEM_WRITE: begin
                mem_we = stat_ff.write_enable_latch & ~protected_addr;
                nxt_frame.addr = 16'(inc_addr);
              end
              `OP_MEM_READ: begin
                nxt_frame.out = mem[cur_addr];
                nxt_frame.addr = 16'(inc_addr);
              end
              // repeat the status byte; the host drops extras
              `OP_STATUS_READ: nxt_frame.out = status_byte;
              `OP_STATUS_WRITE: begin
                nxt_frame.phase = PH_IDLE;
                if (stat_ff.write_enable_latch &
                    ~(stat_ff.protect_pin_enable & ~pin.wp_n)) begin
                  nxt_stat.block_protect_0 = byte_in[`ST_PROT0_BIT];
                  nxt_stat.block_protect_1 = byte_in[`ST_PROT1_BIT];
                  nxt_stat.protect_pin_enable = byte_in[`ST_PIN_EN_BIT];
                end
              end
              default: nxt_frame.phase = PH_IDLE;
            endcase
          end
          PH_IDLE: nxt_frame.phase = PH_IDLE;
        endcase
      end
    end
  end

  // chip select only ends the frame when no pause is in force
  assign frame_clr = sys_ff.link_rst | (pin.cs_n & pin.hold_n);

  // frame state restarts at once, no busy time to wait out
  always_ff @(posedge sck_i or posedge frame_clr) begin
    if (frame_clr) begin
      frame_ff <= '0;
    end else begin
      frame_ff <= nxt_frame;
    end
  end

  // status fields survive frames; changed by the latch and status write opcodes, reset only by system reset
  always_ff @(posedge sck_i or posedge sys_ff.link_rst) begin
    if (sys_ff.link_rst) begin
      stat_ff <= '{default: `ST_RESET_VAL};
    end else if (~pin.cs_n) begin
      stat_ff <= nxt_stat;
    end
  end

  // array write; no reset, contents are kept
  always_ff @(posedge sck_i) begin
    if (mem_we & ~pin.cs_n) begin
      mem[cur_addr] <= byte_in;
    end
  end

  // data out moves on the falling edge so the host samples a settled bit
  always_ff @(negedge sck_i or posedge frame_clr) begin
    if (frame_clr) begin
      so_ff <= 1'b0;
    end else if (pin.hold_n) begin
      so_ff <= frame_ff.out[~frame_ff.bit_cnt];
    end
  end

  // pause level as seen on the link, for the system side
  always_ff @(negedge sck_i or posedge sys_ff.link_rst) begin
    if (sys_ff.link_rst) begin
      hold_lvl_ff <= 1'b0;
    end else begin
      hold_lvl_ff <= ~pin.hold_n & ~pin.cs_n;
    end
  end

  // output floats while paused or outside a read phase
  assign so_oe_n_o = pin.cs_n | ~pin.hold_n | (frame_ff.phase != PH_DATA) |
    ((frame_ff.cmd != `OP_MEM_READ) & (frame_ff.cmd != `OP_STATUS_READ));
  assign so_o = so_ff;

  // status and pause cross as quasi-static levels
  sync2 #(
    .W(9)
  ) u_sync (
    .clk_i(ref_clk_i),
    .d_i({hold_lvl_ff, status_byte}),
    .q_o({paused_sync, status_sync})
  );

  // system side: reset pulse for the link and registered views
  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.link_rst = 1'b0;
    nxt_sys.seen = status_sync;
    // a word caught mid-change is dropped: only two equal samples in a row pass
    if (status_sync == sys_ff.seen) begin
      nxt_sys.status = status_sync;
    end
    nxt_sys.paused = paused_sync;
  end

  // link reset is held one cycle past the release; apply it with the link idle
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sys_ff <= '{link_rst: 1'b1, seen: 8'h00, status: 8'h00, paused: 1'b0};
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  assign status_byte_o = sys_ff.status;
  assign paused_o = sys_ff.paused;

endmodule : serial_nvram

// ==== src/nvram_params.svh ====
// constants of the serial nonvolatile RAM: opcodes, status layout, reset values
// assumes it is included by the package and the bench by bare name
`ifndef NVRAM_PARAMS_SVH
`define NVRAM_PARAMS_SVH

// opcodes
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_READ 8'h03
`define OP_MEM_WRITE 8'h02
`define OP_IGN_WAKE 8'hab
`define OP_IGN_PAGE_ERASE 8'h42
`define OP_IGN_SECTOR_ERASE 8'hd8

// status byte field positions
`define ST_BUSY_BIT 0
`define ST_LATCH_BIT 1
`define ST_PROT0_BIT 2
`define ST_PROT1_BIT 3
`define ST_FIXED_BIT 6
`define ST_PIN_EN_BIT 7

// reset values and defaults
`define ST_RESET_VAL 1'b0
`define ST_FIXED_DEFAULT 1'b0
`define ADDR_W_DEFAULT 11
`define ADDR_BYTES 2
`define LAST_BIT 3'h7

`endif

// ==== src/nvram_pkg.sv ====
// types shared by the serial nonvolatile RAM design files
// assumes nvram_params.svh sits on the include path
`include "nvram_params.svh"

package nvram_pkg;

  // transfer phase of one chip-select frame
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_IDLE = 2'b11
  } phase_t;

  // frame state, cleared when chip select goes high outside a pause
  typedef struct packed {
    phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic addr_byte;
    logic [15:0] addr;
    logic [7:0] out;
  } frame_t;

  // writable status fields, kept across frames
  typedef struct packed {
    logic write_enable_latch;
    logic block_protect_0;
    logic block_protect_1;
    logic protect_pin_enable;
  } stat_t;

  // link pins sampled on the serial clock
  typedef struct packed {
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } link_in_t;

endpackage : nvram_pkg

// ==== src/sync2.sv ====
// two flip-flop synchroniser for a bus of quasi-static levels
// assumes each bit changes rarely; no word coherence is promised
`timescale 1ns/1ps

module sync2 #(
  parameter int W = 8
) (
  // clock of the receiving domain
  input wire logic clk_i,
  // level from the other domain
  input wire logic [W-1:0] d_i,
  // synchronised level
  output logic [W-1:0] q_o
);

  logic [1:0][W-1:0] stage_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    stage_ff <= {stage_ff[0], d_i};
  end

  assign q_o = stage_ff[1];

endmodule : sync2

// ==== dv/serial_nvram_asserts.sv ====
// port checks for the serial nvram: status layout and pause behaviour
// assumes it is bound to serial_nvram and that reset low clears the link
`timescale 1ns/1ps

module serial_nvram_asserts #(
  parameter logic FIXED_BIT6 = 1'b0
) (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  input wire logic [7:0] status_byte_o,
  input wire logic paused_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic [3:0] up_ff;
  // the status copy lags reset release, so the fixed bit waits
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) up_ff <= 4'h0;
    else if (up_ff != 4'hf) up_ff <= up_ff + 4'h1;
  end

  property p_ready;
    status_byte_o[0] == 1'b0;
  endproperty
  a_ready: assert property (p_ready) else $error("status shows busy");
  property p_zero_45;
    status_byte_o[5:4] == 2'h0;
  endproperty
  a_zero_45: assert property (p_zero_45) else $error("status bits 5:4 set");
  property p_fixed6;
    up_ff == 4'hf |-> status_byte_o[6] == FIXED_BIT6;
  endproperty
  a_fixed6: assert property (p_fixed6) else $error("status bit 6 wrong");
  property p_cs_float;
    cs_n_i |-> so_oe_n_o;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("output driven while deselected");
  property p_hold_float;
    !hold_n_i |-> so_oe_n_o;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("output driven in pause");
  property p_pause_flag;
    $rose(paused_o) |-> !hold_n_i;
  endproperty
  a_pause_flag: assert property (p_pause_flag) else $error("pause flag without pause");
  // data out moves on falling serial edges, so it is watched there
  property p_so_frozen;
    @(negedge sck_i) (!hold_n_i) [*2] |-> $stable(so_o);
  endproperty
  a_so_frozen: assert property (p_so_frozen) else $error("data out moved in pause");
  property p_stat_frozen;
    (!hold_n_i) [*6] |-> $stable(status_byte_o);
  endproperty
  a_stat_frozen: assert property (p_stat_frozen) else $error("status moved in pause");
endmodule : serial_nvram_asserts

bind serial_nvram serial_nvram_asserts #(.FIXED_BIT6(FIXED_BIT6)) chk_u (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
  .si_i(si_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o),
  .so_oe_n_o(so_oe_n_o), .status_byte_o(status_byte_o), .paused_o(paused_o)
);

// ==== dv/host_model.sv ====
// serial host model: frame, 48 ns clock, data and pause pins
// assumes mode 0; the clock only runs inside frames
`timescale 1ns/1ps

module host_model (
  // link pins toward the device
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o,
  // data back from the device
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  // idle link at time zero
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end

  // open a frame
  task automatic start();
    cs_n_o = 1'b0;
    #24;
  endtask : start

  // close a frame; data line flips so nothing leans on a stale bit
  task automatic stop();
    #24 cs_n_o = 1'b1;
    si_o = ~si_o;
    #48;
  endtask : stop

  // one byte msb first; a floating output reads back inverted
  task automatic xbyte(input logic [7:0] tx, input logic pz, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (pz && i == 3) begin
        #12 hold_n_o = 1'b0;
        #6 cs_n_o = 1'b1;
        #6 cs_n_o = 1'b0;
        repeat (6) begin
          si_o = ~si_o;
          #24 sck_o = 1'b1;
          #24 sck_o = 1'b0;
        end
        #12 hold_n_o = 1'b1;
      end
      si_o = tx[i];
      #24 sck_o = 1'b1;
      rx[i] = so_oe_n_i ? ~so_i : so_i;
      #24 sck_o = 1'b0;
    end
  endtask : xbyte
endmodule : host_model

// ==== dv/serial_nvram_status_pause_logic_tb.sv ====
// bench: status byte, latch, ignored codes, wrapping burst, pause
// assumes host_model drives the link and the checker is bound
`timescale 1ns/1ps
`include "nvram_params.svh"

module serial_nvram_status_pause_logic_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic sck, cs_n, si, hold_n, so, so_oe_n, paused;
  logic saw_p = 1'b0;
  logic [7:0] stat_o;
  logic [7:0] b[$];
  logic [7:0] rq[$];
  logic [7:0] ign[3] = '{`OP_IGN_WAKE, `OP_IGN_PAGE_ERASE, `OP_IGN_SECTOR_ERASE};
  int mismatches = 0;
  int compares = 0;

  // 25 MHz system clock
  always #20 ref_clk_i = ~ref_clk_i;

  // small array keeps the wrap reachable; bit 6 set to catch a hard zero
  serial_nvram #(.ADDR_W(4), .FIXED_BIT6(1'b1)) dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so),
    .so_oe_n_o(so_oe_n), .status_byte_o(stat_o), .paused_o(paused)
  );
  host_model h (
    .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
    .so_i(so), .so_oe_n_i(so_oe_n)
  );

  // remember that the pause flag showed
  always @(posedge ref_clk_i) if (paused === 1'b1) saw_p <= 1'b1;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one whole frame; byte pz pauses midway
  task automatic frame(input logic [7:0] q[$], input int pz);
    logic [7:0] r;
    rq = {};
    h.start();
    foreach (q[i]) begin
      h.xbyte(q[i], i == pz, r);
      rq.push_back(r);
    end
    h.stop();
  endtask : frame

  // status over the link, then the system copy once settled
  task automatic stat(input logic [7:0] e);
    frame('{`OP_STATUS_READ, 8'h00}, 99);
    chk("status", e, rq[1]);
    chk("status_used", e & 8'h8f, rq[1] & 8'h8f);
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("status_o", e, stat_o);
  endtask : stat

  task automatic wrap_up();
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // main sequence, frames back to back
  initial begin
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    stat(8'h40);
    frame('{`OP_LATCH_SET}, 99);
    stat(8'h42);
    frame('{`OP_STATUS_WRITE, 8'hff}, 99);
    stat(8'hce);
    // pin enable set and protect pin low: status write must be refused
    @(posedge ref_clk_i);
    wp_n_i <= 1'b0;
    frame('{`OP_STATUS_WRITE, 8'h00}, 99);
    stat(8'hce);
    @(posedge ref_clk_i);
    wp_n_i <= 1'b1;
    frame('{`OP_STATUS_WRITE, 8'h00}, 99);
    stat(8'h42);
    foreach (ign[i]) begin
      frame('{ign[i], `OP_LATCH_CLEAR}, 99);
      stat(8'h42);
    end
    b = '{`OP_MEM_WRITE, 8'h00, 8'h0e};
    for (int i = 0; i < 16; i++) b.push_back(8'h30 + 8'(i));
    frame(b, 99);
    b = '{`OP_MEM_READ, 8'h00, 8'h00};
    for (int i = 0; i < 17; i++) b.push_back(8'h00);
    frame(b, 3);
    for (int i = 0; i < 17; i++) chk("mem", 8'h30 + 8'((i + 2) % 16), rq[3 + i]);
    chk("paused", 8'h01, {7'h00, saw_p});
    chk("paused_o", 8'h00, {7'h00, paused});
    // upper half protected: last location keeps its byte, the wrap target takes one
    frame('{`OP_STATUS_WRITE, 8'h08}, 99);
    frame('{`OP_MEM_WRITE, 8'h00, 8'h0f, 8'haa, 8'hbb}, 99);
    frame('{`OP_MEM_READ, 8'h00, 8'h0f, 8'h00, 8'h00}, 99);
    chk("protected", 8'h31, rq[3]);
    chk("open", 8'hbb, rq[4]);
    frame('{`OP_STATUS_WRITE, 8'h00}, 99);
    frame('{`OP_LATCH_CLEAR}, 99);
    stat(8'h40);
    wrap_up();
  end

  // hang guard, far past the expected 40 us
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule : serial_nvram_status_pause_logic_tb
